// *** core/acm_map.svh ***
// register offsets, field positions, reset values and counts of the attribute colour mapper
`ifndef ACM_MAP_SVH
`define ACM_MAP_SVH

`define ACM_PORT_SHARED    16'h03c0
`define ACM_PORT_RDATA     16'h03c1
`define ACM_PORT_STAT_MONO 16'h03ba
`define ACM_PORT_STAT_COLR 16'h03da

`define ACM_IDX_MODE       5'h10
`define ACM_IDX_PLANE      5'h12
`define ACM_IDX_PAN        5'h13
`define ACM_IDX_CSEL       5'h14
`define ACM_IDX_MAP_LAST   5'h0f

`define ACM_BIT_VIDEO_EN   5
`define ACM_BIT_P54_SEL    7
`define ACM_BIT_WIDE       6
`define ACM_BIT_PAN_UPPER  5
`define ACM_BIT_BLINK      3
`define ACM_BIT_LINE_GFX   2
`define ACM_BIT_MONO       1
`define ACM_BIT_GRAPHICS   0

`define ACM_LINE_GFX_LO    8'hb0
`define ACM_LINE_GFX_HI    8'hdf

`define ACM_RST_REG        8'h00
`define ACM_BUF_DEPTH      2

`endif

// *** core/acm_pkg.sv ***
// types shared by the attribute colour mapper
package acm_pkg;
  typedef enum logic {ACM_FF_INDEX, ACM_FF_DATA} acm_ff_t;
  typedef enum logic [1:0] {ACM_CELL_8, ACM_CELL_9, ACM_CELL_PSEUDO9} acm_cell_t;
endpackage

// *** core/acm_mapper.sv ***
// attribute colour mapper: indexed host registers and pixel attribute to palette index path
// Behaviour
// R1: each write to the shared port flips between index load and data load
// R2: reading the status port for the current emulation forces index-load state
// R3: index written to shared port selects what the read-data port returns
// R4: reads of the read-data port leave the index/data flip-flop alone
// R5: index bits 4:0 pick registers 00h..14h; index bits 7:6 read zero
// R6: index bit 5 clear blanks pixels to zero and opens the mapping registers
// R7: sixteen mapping registers hold six bits each; bits 7:6 read zero
// R8: mode bit 7 takes index bits 5:4 from colour select bits 1:0
// R9: mode bit 6 pairs two nibbles into one byte every other pixel, bypassing map
// R10: mode bit 5 set limits panning to the upper split region
// R11: mode bit 3 enables blinking; clear makes attribute bit 7 background intensity
// R12: blink phase comes from divided vertical sync using an external rate
// R13: ninth cell pixel is background, or repeats eighth for codes B0h..DFh
// R14: mode bit 1 selects colour or monochrome attribute interpretation
// R15: mode bit 0 selects text or graphics; software keeps it consistent
// R16: plane enable bits 5:4 steer two palette index bits to status bits
// R17: plane enable bits 3:0 force disabled plane bits to zero
// R18: panning value maps to pixel shift by nine, pseudo nine and eight dot cells
// R19: in 256-colour mode even panning values 0..6 shift by half their value; odd values and values above 6 shift by zero
// R20: colour select bits 3:2 supply palette index bits 7:6
// R21: colour select bits 1:0 are alternate index bits 5:4
// R22: sixteen-colour index is select bits, chosen bits 5:4 and map bits 3:0
`timescale 1ns/1ps
`include "acm_map.svh"

module acm_mapper (
  input  wire logic              REF_CLK,
  input  wire logic              RST,
  input  wire logic [15:0]       IO_ADDR,
  input  wire logic              IO_WR,
  input  wire logic              IO_RD,
  input  wire logic [7:0]        IO_WDATA,
  output logic      [7:0]        IO_RDATA,
  output logic                   IO_RD_ACK,
  input  wire logic              MISC_COLOR_EMU,
  input  wire logic              VSYNC,
  input  wire logic [3:0]        BLINK_RATE,
  input  wire acm_pkg::acm_cell_t CELL_MODE,
  input  wire logic              PIX_VALID,
  output logic                   PIX_READY,
  input  wire logic [3:0]        PIX_PLANES,
  input  wire logic [7:0]        PIX_ATTR,
  input  wire logic [7:0]        PIX_CHAR,
  input  wire logic              PIX_FONT,
  input  wire logic              PIX_NINTH,
  input  wire logic              PIX_LOWER,
  output logic                   OUT_VALID,
  input  wire logic              OUT_READY,
  output logic      [7:0]        OUT_INDEX,
  output logic      [3:0]        PAN_PIXELS,
  output logic      [1:0]        STATUS_P54,
  output logic                   GRAPHICS_MODE
);
  import acm_pkg::*;

  acm_ff_t     ff_r;
  logic [7:0]  index_r;
  logic [5:0]  map_r [0:15];
  logic [7:0]  mode_r;
  logic [5:0]  plane_r;
  logic [3:0]  pan_r;
  logic [3:0]  csel_r;
  logic [7:0]  rdata_r;
  logic        rd_ack_r;

  logic        wr_shared;
  logic        rd_data;
  logic        rd_status;
  logic        map_open;
  logic [4:0]  sel;

  assign wr_shared = IO_WR && (IO_ADDR == `ACM_PORT_SHARED);
  assign rd_data   = IO_RD && (IO_ADDR == `ACM_PORT_RDATA);
  assign rd_status = IO_RD && (IO_ADDR == (MISC_COLOR_EMU ? `ACM_PORT_STAT_COLR
                                                         : `ACM_PORT_STAT_MONO));
  assign sel       = index_r[4:0];
  assign map_open  = !index_r[`ACM_BIT_VIDEO_EN];

  // a write in the same cycle as the status read wins: it is the newer request
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ff_r <= ACM_FF_INDEX;
    end else if (wr_shared) begin
      ff_r <= (ff_r == ACM_FF_INDEX) ? ACM_FF_DATA : ACM_FF_INDEX; // [R1]
    end else if (rd_status) begin
      ff_r <= ACM_FF_INDEX; // [R2]
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      index_r <= `ACM_RST_REG;
    end else if (wr_shared && ff_r == ACM_FF_INDEX) begin
      index_r <= {2'b00, IO_WDATA[5:0]}; // [R5]
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      for (int i = 0; i < 16; i++) begin
        map_r[i] <= 6'h00;
      end
      mode_r  <= `ACM_RST_REG;
      plane_r <= 6'h00;
      pan_r   <= 4'h0;
      csel_r  <= 4'h0;
    end else if (wr_shared && ff_r == ACM_FF_DATA) begin
      if (sel <= `ACM_IDX_MAP_LAST) begin
        if (map_open) begin
          map_r[sel[3:0]] <= IO_WDATA[5:0]; // [R6] [R7]
        end
      end else begin
        case (sel)
          `ACM_IDX_MODE:  mode_r  <= {IO_WDATA[7:5], 1'b0, IO_WDATA[3:0]};
          `ACM_IDX_PLANE: plane_r <= IO_WDATA[5:0];
          `ACM_IDX_PAN:   pan_r   <= IO_WDATA[3:0];
          `ACM_IDX_CSEL:  csel_r  <= IO_WDATA[3:0];
          default: ;
        endcase
      end
    end
  end

  // closed mapping entries read as zero so software sees them as inaccessible
  function automatic logic [7:0] reg_read(input logic [4:0] s);
    logic [7:0] v;
    v = 8'h00;
    if (s <= `ACM_IDX_MAP_LAST) begin
      v = map_open ? {2'b00, map_r[s[3:0]]} : 8'h00; // [R6] [R7]
    end else begin
      case (s)
        `ACM_IDX_MODE:  v = mode_r;
        `ACM_IDX_PLANE: v = {2'b00, plane_r};
        `ACM_IDX_PAN:   v = {4'h0, pan_r};
        `ACM_IDX_CSEL:  v = {4'h0, csel_r};
        default:        v = 8'h00;
      endcase
    end
    return v;
  endfunction

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      rdata_r  <= 8'h00;
      rd_ack_r <= 1'b0;
    end else begin
      rd_ack_r <= 1'b0;
      if (IO_RD && IO_ADDR == `ACM_PORT_SHARED) begin
        rdata_r  <= index_r; // [R5]
        rd_ack_r <= 1'b1;
      end else if (rd_data) begin
        rdata_r  <= reg_read(sel); // [R3]
        rd_ack_r <= 1'b1;
      end
    end
  end

  assign IO_RDATA      = rdata_r;
  assign IO_RD_ACK     = rd_ack_r;
  assign GRAPHICS_MODE = mode_r[`ACM_BIT_GRAPHICS]; // [R15]

  // vertical sync comes from the timing block on its own schedule, so it is synchronised
  logic       vs_s1_r;
  logic       vs_s2_r;
  logic       vs_s3_r;
  logic [3:0] blink_cnt_r;
  logic       blink_r;

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      vs_s1_r <= 1'b0;
      vs_s2_r <= 1'b0;
      vs_s3_r <= 1'b0;
    end else begin
      vs_s1_r <= VSYNC;
      vs_s2_r <= vs_s1_r;
      vs_s3_r <= vs_s2_r;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      blink_cnt_r <= 4'h0;
      blink_r     <= 1'b0;
    end else if (vs_s2_r && !vs_s3_r) begin
      if (blink_cnt_r >= BLINK_RATE) begin
        blink_cnt_r <= 4'h0;
        blink_r     <= !blink_r; // [R12]
      end else begin
        blink_cnt_r <= blink_cnt_r + 4'h1;
      end
    end
  end

  function automatic logic [7:0] map16(input logic [3:0] c);
    logic [1:0] p54;
    p54 = mode_r[`ACM_BIT_P54_SEL] ? csel_r[1:0] : map_r[c][5:4]; // [R8] [R21]
    return {csel_r[3:2], p54, map_r[c][3:0]}; // [R20] [R22]
  endfunction

  // colour nibble before mapping; the ninth pixel repeats the eighth only for line art
  logic       last_font_r;
  logic       font_eff;
  logic       line_char;
  logic [3:0] nib;
  logic       fg_blank;

  assign line_char = (PIX_CHAR >= `ACM_LINE_GFX_LO) && (PIX_CHAR <= `ACM_LINE_GFX_HI);

  always_comb begin
    font_eff = PIX_FONT;
    if (PIX_NINTH) begin
      font_eff = mode_r[`ACM_BIT_LINE_GFX] && line_char && last_font_r; // [R13]
    end
    fg_blank = mode_r[`ACM_BIT_BLINK] && PIX_ATTR[7] && blink_r; // [R11]
    nib = 4'h0;
    if (mode_r[`ACM_BIT_GRAPHICS]) begin
      nib = PIX_PLANES & plane_r[3:0]; // [R17]
      if (mode_r[`ACM_BIT_BLINK] && blink_r) begin
        nib[3] = 1'b0; // [R11]
      end
    end else if (mode_r[`ACM_BIT_MONO]) begin
      nib = (font_eff && !fg_blank) ? {PIX_ATTR[3], 3'b111} // [R14]
          : {PIX_ATTR[7] && !mode_r[`ACM_BIT_BLINK], 3'b000};
    end else if (font_eff && !fg_blank) begin
      nib = PIX_ATTR[3:0];
    end else begin
      nib = {PIX_ATTR[7] && !mode_r[`ACM_BIT_BLINK], PIX_ATTR[6:4]}; // [R11]
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      last_font_r <= 1'b0;
    end else if (PIX_VALID && PIX_READY) begin
      last_font_r <= PIX_FONT;
    end
  end

  // wide mode: first nibble is held, the pair goes out as one byte on the second
  logic       wide;
  logic       half_r;
  logic [3:0] first_r;
  logic       take;
  logic       push;
  logic [7:0] push_idx;

  assign wide = mode_r[`ACM_BIT_WIDE];
  assign take = PIX_VALID && PIX_READY;
  assign push = take && (!wide || half_r);

  always_comb begin
    if (!index_r[`ACM_BIT_VIDEO_EN]) begin
      push_idx = 8'h00; // [R6]
    end else if (wide) begin
      push_idx = {first_r, nib}; // [R9]
    end else begin
      push_idx = map16(nib);
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      half_r  <= 1'b0;
      first_r <= 4'h0;
    end else if (!wide) begin
      half_r <= 1'b0;
    end else if (take) begin
      half_r  <= !half_r; // [R9]
      first_r <= nib;
    end
  end

  // two-entry output buffer so a stalled receiver drops no index
  logic [7:0] buf_r [0:`ACM_BUF_DEPTH-1];
  logic       wp_r;
  logic       rp_r;
  logic [1:0] cnt_r;
  logic       pop;

  assign pop       = OUT_VALID && OUT_READY;
  assign PIX_READY = (cnt_r != 2'd2) || OUT_READY;
  assign OUT_VALID = (cnt_r != 2'd0);
  assign OUT_INDEX = buf_r[rp_r];

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      cnt_r <= 2'd0;
      for (int i = 0; i < `ACM_BUF_DEPTH; i++) begin
        buf_r[i] <= 8'h00;
      end
    end else begin
      if (push) begin
        buf_r[wp_r] <= push_idx;
        wp_r        <= !wp_r;
      end
      if (pop) begin
        rp_r <= !rp_r;
      end
      case ({push, pop})
        2'b10:   cnt_r <= cnt_r + 2'd1;
        2'b01:   cnt_r <= cnt_r - 2'd1;
        default: cnt_r <= cnt_r;
      endcase
    end
  end

  // status bits follow the index leaving the buffer
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      STATUS_P54 <= 2'b00;
    end else if (pop) begin
      case (plane_r[5:4]) // [R16]
        2'b00:   STATUS_P54 <= {OUT_INDEX[2], OUT_INDEX[0]};
        2'b01:   STATUS_P54 <= {OUT_INDEX[5], OUT_INDEX[4]};
        2'b10:   STATUS_P54 <= {OUT_INDEX[3], OUT_INDEX[1]};
        default: STATUS_P54 <= {OUT_INDEX[7], OUT_INDEX[6]};
      endcase
    end
  end

  // undefined table entries shift by zero rather than something arbitrary
  function automatic logic [3:0] pan_shift(input logic [3:0] v, input acm_cell_t cm,
                                           input logic w);
    logic [3:0] s;
    s = 4'h0;
    if (w) begin
      s = (v[0] || v > 4'h6) ? 4'h0 : {1'b0, v[3:1]}; // [R19]
    end else if (v > 4'h8) begin
      s = 4'h0;
    end else begin
      case (cm) // [R18]
        ACM_CELL_9:      s = (v == 4'h8) ? 4'h0 : v + 4'h1;
        ACM_CELL_PSEUDO9: s = (v == 4'h8) ? 4'h0 : (v == 4'h7) ? 4'h7 : v + 4'h1;
        default:         s = (v == 4'h8) ? 4'h0 : v;
      endcase
    end
    return s;
  endfunction

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      PAN_PIXELS <= 4'h0;
    end else if (PIX_LOWER && mode_r[`ACM_BIT_PAN_UPPER]) begin
      PAN_PIXELS <= 4'h0; // [R10]
    end else begin
      PAN_PIXELS <= pan_shift(pan_r, CELL_MODE, wide);
    end
  end

  AST_FF_TOGGLE: assert property (@(posedge REF_CLK) disable iff (RST) // [R1]
    wr_shared |=> ff_r != $past(ff_r)) else $error("shared port write did not flip state");

  AST_STATUS_RESET: assert property (@(posedge REF_CLK) disable iff (RST) // [R2]
    rd_status && !wr_shared |=> ff_r == ACM_FF_INDEX) else $error("status read kept data state");

  AST_RD_ANSWER: assert property (@(posedge REF_CLK) disable iff (RST) // [R3]
    rd_data |=> IO_RD_ACK && IO_RDATA == reg_read($past(sel)))
    else $error("read-data port answer wrong");

  AST_RD_KEEPS: assert property (@(posedge REF_CLK) disable iff (RST) // [R4]
    rd_data && !wr_shared |=> $stable(ff_r)) else $error("data read moved the flip-flop");

  AST_RSVD_ZERO: assert property (@(posedge REF_CLK) disable iff (RST) // [R5]
    IO_RD_ACK && $past(sel) != `ACM_IDX_MODE |-> IO_RDATA[7:6] == 2'b00)
    else $error("reserved high bits not zero");

  AST_BLANK: assert property (@(posedge REF_CLK) disable iff (RST) // [R6]
    push && map_open |-> push_idx == 8'h00) else $error("pixel not blanked");

  AST_P76: assert property (@(posedge REF_CLK) disable iff (RST) // [R20]
    push && !wide && !map_open |-> push_idx[7:6] == csel_r[3:2])
    else $error("upper palette bits wrong");

  AST_P54_ALT: assert property (@(posedge REF_CLK) disable iff (RST) // [R8]
    push && !wide && !map_open && mode_r[7] |-> push_idx[5:4] == csel_r[1:0])
    else $error("alternate bits 5:4 not used");

  AST_WIDE_RATE: assert property (@(posedge REF_CLK) disable iff (RST) // [R9]
    push && wide ##1 wide |-> !push) else $error("wide mode pushed twice in a row");

  AST_PAN_SPLIT: assert property (@(posedge REF_CLK) disable iff (RST) // [R10]
    PIX_LOWER && mode_r[5] |=> PAN_PIXELS == 4'h0) else $error("lower region panned");

endmodule

// *** testbench/tb_acm_mapper.sv ***
// self-checking testbench of the attribute colour mapper
`timescale 1ns/1ps
`include "acm_map.svh"

module tb_acm_mapper;
  import acm_pkg::*;

  logic        ref_clk, rst, io_wr, io_rd, io_rd_ack, misc_color_emu, vsync;
  logic [15:0] io_addr;
  logic [7:0]  io_wdata, io_rdata, pix_attr, pix_char, out_index, v, v1;
  logic [3:0]  blink_rate, pix_planes, pan_pixels;
  logic [1:0]  status_p54;
  logic        pix_valid, pix_ready, pix_font, pix_ninth, pix_lower;
  logic        out_valid, out_ready, graphics_mode, took;
  acm_cell_t   cell_mode;
  int          err_count, n_tests;

  acm_mapper i_acm_mapper (.REF_CLK(ref_clk), .RST(rst), .IO_ADDR(io_addr), .IO_WR(io_wr),
    .IO_RD(io_rd), .IO_WDATA(io_wdata), .IO_RDATA(io_rdata), .IO_RD_ACK(io_rd_ack),
    .MISC_COLOR_EMU(misc_color_emu), .VSYNC(vsync), .BLINK_RATE(blink_rate),
    .CELL_MODE(cell_mode), .PIX_VALID(pix_valid), .PIX_READY(pix_ready),
    .PIX_PLANES(pix_planes), .PIX_ATTR(pix_attr), .PIX_CHAR(pix_char), .PIX_FONT(pix_font),
    .PIX_NINTH(pix_ninth), .PIX_LOWER(pix_lower), .OUT_VALID(out_valid),
    .OUT_READY(out_ready), .OUT_INDEX(out_index), .PAN_PIXELS(pan_pixels),
    .STATUS_P54(status_p54), .GRAPHICS_MODE(graphics_mode));

  initial begin
    ref_clk = 0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic conclude();
    if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    io_addr = a; io_wdata = d; io_wr = 1;
    @(negedge ref_clk);
    io_wr = 0;
  endtask

  // status reads get no answer; the ack is looked at in its single cycle
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    logic ans;
    ans = (a == `ACM_PORT_SHARED || a == `ACM_PORT_RDATA);
    @(negedge ref_clk);
    io_addr = a; io_rd = 1;
    @(negedge ref_clk);
    io_rd = 0;
    chk({7'h0, io_rd_ack}, {7'h0, ans});
    if (ans) chk(io_rdata, exp);
  endtask

  task automatic ar(input logic [7:0] idx, input logic [7:0] d);
    wr(`ACM_PORT_SHARED, idx);
    wr(`ACM_PORT_SHARED, d);
  endtask

  task automatic push(input logic [3:0] pl, input logic [7:0] at, input logic ft,
                      input logic nn);
    @(negedge ref_clk);
    pix_planes = pl; pix_attr = at; pix_font = ft; pix_ninth = nn; pix_valid = 1;
    for (int i = 0; i < 3 && pix_ready !== 1'b1; i++) @(negedge ref_clk);
    took = (pix_ready === 1'b1);
    @(negedge ref_clk);
    pix_valid = 0;
  endtask

  task automatic pop(output logic [7:0] got);
    for (int i = 0; i < 20 && out_valid !== 1'b1; i++) @(negedge ref_clk);
    chk({7'h0, out_valid}, 8'h01);
    got = out_index; out_ready = 1;
    @(negedge ref_clk);
    out_ready = 0;
  endtask

  task automatic px(input logic [7:0] exp);
    logic [7:0] got;
    pop(got);
    chk(got, exp);
  endtask

  task automatic vsync_pulse();
    repeat (3) @(negedge ref_clk);
    vsync = 1;
    repeat (4) @(negedge ref_clk);
    vsync = 0;
    repeat (6) @(negedge ref_clk);
  endtask

  task automatic t_regs();
    ar(8'h10, 8'h19);
    rd(`ACM_PORT_RDATA, 8'h09);
    rd(`ACM_PORT_SHARED, 8'h10);
    wr(`ACM_PORT_SHARED, 8'hd2);
    rd(`ACM_PORT_SHARED, 8'h12);
    rd(`ACM_PORT_RDATA, 8'h00);
    wr(`ACM_PORT_SHARED, 8'h3c);
    rd(`ACM_PORT_RDATA, 8'h3c);
    wr(`ACM_PORT_SHARED, 8'h13);
    misc_color_emu = 1;
    rd(`ACM_PORT_STAT_COLR, 8'h00);
    ar(8'h14, 8'h05);
    rd(`ACM_PORT_RDATA, 8'h05);
    wr(`ACM_PORT_SHARED, 8'h14);
    misc_color_emu = 0;
    rd(`ACM_PORT_STAT_MONO, 8'h00);
    ar(8'h14, 8'h0a);
    rd(`ACM_PORT_RDATA, 8'h0a);
    misc_color_emu = 1;
  endtask

  task automatic t_map();
    for (int i = 0; i < 16; i++) ar(i[7:0], 8'hd0 | i[7:0]);
    for (int i = 0; i < 16; i++) begin
      wr(`ACM_PORT_SHARED, i[7:0]);
      rd(`ACM_PORT_RDATA, 8'h10 | i[7:0]);
      rd(`ACM_PORT_STAT_COLR, 8'h00);
    end
    wr(`ACM_PORT_SHARED, 8'h25);
    rd(`ACM_PORT_RDATA, 8'h00);
    wr(`ACM_PORT_SHARED, 8'h3f);
    wr(`ACM_PORT_SHARED, 8'h05);
    rd(`ACM_PORT_RDATA, 8'h15);
    rd(`ACM_PORT_STAT_COLR, 8'h00);
  endtask

  // video stays enabled from here on: every index written carries bit 5 except the 00h of the blanking check in t_pix
  task automatic t_pix();
    logic [7:0] p;
    ar(8'h30, 8'h01); ar(8'h32, 8'h0f); ar(8'h34, 8'h0c);
    chk({7'h0, graphics_mode}, 8'h01);
    p = 8'hd5;
    for (int s = 0; s < 4; s++) begin
      ar(8'h32, 8'h0f | (s[7:0] << 4));
      push(4'h5, 8'h00, 0, 0);
      px(p);
      chk({6'h0, status_p54}, s == 0 ? {6'h0, p[2], p[0]} : s == 1 ? {6'h0, p[5:4]} :
          s == 2 ? {6'h0, p[3], p[1]} : {6'h0, p[7:6]});
    end
    ar(8'h30, 8'h81); ar(8'h34, 8'h0e);
    push(4'h5, 8'h00, 0, 0);
    px(8'he5);
    ar(8'h32, 8'h0e);
    push(4'h5, 8'h00, 0, 0);
    px(8'he4);
    wr(`ACM_PORT_SHARED, 8'h00);
    rd(`ACM_PORT_STAT_COLR, 8'h00);
    push(4'hf, 8'h00, 0, 0);
    px(8'h00);
    ar(8'h30, 8'h01); ar(8'h32, 8'h0f); ar(8'h34, 8'h00);
  endtask

  task automatic t_buf();
    push(4'ha, 8'h00, 0, 0);
    push(4'hb, 8'h00, 0, 0);
    push(4'hc, 8'h00, 0, 0);
    chk({7'h0, took}, 8'h00);
    px(8'h1a);
    px(8'h1b);
    ar(8'h30, 8'h41);
    push(4'ha, 8'h00, 0, 0);
    repeat (2) @(negedge ref_clk);
    chk({7'h0, out_valid}, 8'h00);
    push(4'h5, 8'h00, 0, 0);
    px(8'ha5);
  endtask

  task automatic t_text();
    ar(8'h30, 8'h00);
    push(4'h0, 8'h95, 1, 0);
    px(8'h15);
    push(4'h0, 8'h95, 0, 0);
    px(8'h19);
    cell_mode = ACM_CELL_9; pix_char = 8'hc4;
    push(4'h0, 8'h95, 1, 1);
    px(8'h19);
    ar(8'h30, 8'h04);
    push(4'h0, 8'h95, 1, 0);
    px(8'h15);
    push(4'h0, 8'h95, 0, 1);
    px(8'h15);
    pix_char = 8'ha0;
    push(4'h0, 8'h95, 1, 0);
    px(8'h15);
    push(4'h0, 8'h95, 0, 1);
    px(8'h19);
    // monochrome: foreground keeps only the underline-style bit 3, background only intensity
    ar(8'h30, 8'h02);
    push(4'h0, 8'h95, 1, 0);
    px(8'h17);
    push(4'h0, 8'h95, 0, 0);
    px(8'h18);
  endtask

  task automatic t_blink();
    ar(8'h30, 8'h08); blink_rate = 4'h1;
    push(4'h0, 8'h95, 1, 0);
    pop(v1);
    chk(v1, 8'h15);
    vsync_pulse();
    push(4'h0, 8'h95, 1, 0);
    pop(v);
    chk(v, v1);
    vsync_pulse();
    push(4'h0, 8'h95, 1, 0);
    pop(v);
    chk(v, v1 ^ 8'h04);
    // blink phase is now on: graphics with blinking loses bit 3, without it keeps it
    ar(8'h30, 8'h09);
    push(4'hf, 8'h00, 0, 0);
    px(8'h17);
    ar(8'h30, 8'h01);
    push(4'hf, 8'h00, 0, 0);
    px(8'h1f);
  endtask

  task automatic t_pan();
    logic [3:0] e;
    ar(8'h30, 8'h00);
    for (int c = 0; c < 3; c++) begin
      cell_mode = acm_cell_t'(c);
      for (int p = 0; p < 9; p++) begin
        ar(8'h33, p[7:0]);
        repeat (3) @(negedge ref_clk);
        if (c == 0) e = p < 8 ? p[3:0] : 4'h0;
        else e = p == 8 ? 4'h0 : (c == 2 && p == 7) ? 4'h7 : p[3:0] + 4'h1;
        chk({4'h0, pan_pixels}, {4'h0, e});
      end
    end
    cell_mode = ACM_CELL_8; ar(8'h30, 8'h40);
    for (int p = 0; p < 7; p += 2) begin
      ar(8'h33, p[7:0]);
      repeat (3) @(negedge ref_clk);
      chk({4'h0, pan_pixels}, p[8:1]);
    end
    ar(8'h33, 8'h03); pix_lower = 1; ar(8'h30, 8'h20);
    repeat (3) @(negedge ref_clk);
    chk({4'h0, pan_pixels}, 8'h00);
    ar(8'h30, 8'h00);
    repeat (3) @(negedge ref_clk);
    chk({4'h0, pan_pixels}, 8'h03);
  endtask

  initial begin
    err_count = 0; n_tests = 0; rst = 1; io_wr = 0; io_rd = 0; io_addr = 16'h0000;
    io_wdata = 8'h00; misc_color_emu = 1; vsync = 0; blink_rate = 4'h0;
    cell_mode = ACM_CELL_8; pix_valid = 0; pix_planes = 4'h0; pix_attr = 8'h00;
    pix_char = 8'h00; pix_font = 0; pix_ninth = 0; pix_lower = 0; out_ready = 0; took = 0;
    repeat (5) @(negedge ref_clk);
    rst = 0;
    t_regs();
    t_map();
    t_pix();
    t_buf();
    t_text();
    t_blink();
    t_pan();
    conclude();
  end

  // the whole sequence needs some 650 cycles; this limit is well beyond it
  initial begin
    #1000000;
    err_count++;
    conclude();
  end
endmodule
